/* design/smw_pkg.sv */
// Overview of operation
// [R1] float waits before read to other memory
// [R2] float waits before any following write
// [R3] per chip select float count 0..15
// [R4] float never delays internal accesses
// [R5] read strobe mode: float after strobe rise
// [R6] chip select mode: float after select rise
// [R7] optimised: next setup absorbs float period
// [R8] unoptimised: float over before next access
// [R9] control hold cycles count toward float
// [R10] wait mode 00 off, 10 frozen, 11 ready
// [R11] software: hold cycle, no slow/page wait
// [R12] wait input sampled only in pulse phase
// [R13] frozen: counters and outputs held steady
// [R14] ready: check in last pulse, then suspend
// [R15] ready: early release or late assert ignored
// [R16] software: pulse covers latency plus three
// [R17] slow clock forces fixed waveforms everywhere
// [R18] slow read: 1/1, select 0/2, cycle 2
// [R19] slow write: 1/1, select 0/3, cycle 3
// [R20] running transfer keeps its slow waveform
// [R21] slow mode change adds one reload cycle
// [R22] reset clears float and leaves idle
package smw_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CS = 8;
  localparam int CS_W   = 3;
  localparam int CNT_W  = 10;
  localparam int TDF_W  = 4;

  // ----------------------------------------------------------------
  // external wait modes
  // ----------------------------------------------------------------
  localparam logic [1:0] WMODE_OFF    = 2'h0;
  localparam logic [1:0] WMODE_FROZEN = 2'h2;
  localparam logic [1:0] WMODE_READY  = 2'h3;

  // ----------------------------------------------------------------
  // fixed slow clock waveforms
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] SLOW_RD_SETUP    = 10'h001;
  localparam logic [CNT_W-1:0] SLOW_RD_PULSE    = 10'h001;
  localparam logic [CNT_W-1:0] SLOW_CS_RD_SETUP = 10'h000;
  localparam logic [CNT_W-1:0] SLOW_CS_RD_PULSE = 10'h002;
  localparam logic [CNT_W-1:0] SLOW_RD_CYCLE    = 10'h002;
  localparam logic [CNT_W-1:0] SLOW_WR_SETUP    = 10'h001;
  localparam logic [CNT_W-1:0] SLOW_WR_PULSE    = 10'h001;
  localparam logic [CNT_W-1:0] SLOW_CS_WR_SETUP = 10'h000;
  localparam logic [CNT_W-1:0] SLOW_CS_WR_PULSE = 10'h003;
  localparam logic [CNT_W-1:0] SLOW_WR_CYCLE    = 10'h003;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic             RST_WAIT_N = 1'b1;
  localparam logic [TDF_W-1:0] RST_FLOAT  = 4'h0;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_FLOAT   = 5'h02,
    ST_RELOAD  = 5'h04,
    ST_ACCESS  = 5'h08,
    ST_SUSPEND = 5'h10
  } smw_state_t;

endpackage

/* design/smw_sync.sv */
`timescale 1ns/1ns
module smw_sync
  import smw_pkg::*;
#(
  parameter logic RST_VAL = smw_pkg::RST_WAIT_N
) (
  input  wire logic clk,     // master clock
  input  wire logic resetn,  // async reset, active low
  input  wire logic ce,      // clock enable
  input  wire logic d,       // asynchronous level
  output logic      q        // synchronised level
);

  typedef struct packed {
    logic s1;
    logic s2;
  } smw_sync_t;

  smw_sync_t r;
  smw_sync_t next_r;

  // ----------------------------------------------------------------
  // two flops; the first is read only by the second
  // ----------------------------------------------------------------
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{s1: RST_VAL, s2: RST_VAL};
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule

/* design/smw_wait_ctrl.sv */
`timescale 1ns/1ns
module smw_wait_ctrl
  import smw_pkg::*;
#(
  parameter int NUM_CS = smw_pkg::NUM_CS,
  parameter int CS_W   = smw_pkg::CS_W,
  parameter int CNT_W  = smw_pkg::CNT_W,
  parameter int TDF_W  = smw_pkg::TDF_W
) (
  input  wire logic                          clk,                // master clock
  input  wire logic                          resetn,             // async reset, active low
  input  wire logic                          ce,                 // clock enable
  input  wire logic                          slow_clock,         // power manager slow indication
  input  wire logic                          int_req,            // internal memory access
  input  wire logic                          ext_req,            // external access, held to done
  input  wire logic                          ext_write,          // 1 write, 0 read
  input  wire logic [CS_W-1:0]               ext_cs,             // target chip select
  input  wire logic [CNT_W-1:0]              read_strobe_setup,  // effective read strobe setup
  input  wire logic [CNT_W-1:0]              read_strobe_pulse,  // effective read strobe pulse
  input  wire logic [CNT_W-1:0]              read_cycle_len,     // effective read cycle
  input  wire logic [CNT_W-1:0]              cs_read_setup,      // select setup on read
  input  wire logic [CNT_W-1:0]              cs_read_pulse,      // select pulse on read
  input  wire logic [CNT_W-1:0]              write_strobe_setup, // effective write strobe setup
  input  wire logic [CNT_W-1:0]              write_strobe_pulse, // effective write strobe pulse
  input  wire logic [CNT_W-1:0]              write_cycle_len,    // effective write cycle
  input  wire logic [CNT_W-1:0]              cs_write_setup,     // select setup on write
  input  wire logic [CNT_W-1:0]              cs_write_pulse,     // select pulse on write
  input  wire logic [NUM_CS-1:0]             read_mode,          // 1 strobe, 0 select controls read
  input  wire logic [NUM_CS-1:0]             float_opt,          // float optimisation enable
  input  wire logic [NUM_CS-1:0][TDF_W-1:0]  float_cycles,       // float count per select
  input  wire logic [NUM_CS-1:0][1:0]        ext_wait_mode,      // wait mode per select
  input  wire logic                          ext_wait_n,         // external wait, active low
  output logic                               read_strobe_n,      // read strobe
  output logic                               write_strobe_n,     // write strobe
  output logic [NUM_CS-1:0]                  chip_select_n,      // chip selects
  output logic                               ext_done,           // external access done pulse
  output logic                               int_done,           // internal access done pulse
  output logic [TDF_W-1:0]                   float_left,         // float cycles still pending
  output logic                               wait_frozen,        // access frozen by wait
  output logic                               wait_suspended,     // access suspended by wait
  output logic                               slow_active         // slow waveforms applied
);

  typedef struct packed {
    smw_state_t             st;
    logic [CNT_W-1:0]       cnt;
    logic                   wr;
    logic [CS_W-1:0]        cs;
    logic [CNT_W-1:0]       s_setup;
    logic [CNT_W-1:0]       s_pulse;
    logic [CNT_W-1:0]       c_setup;
    logic [CNT_W-1:0]       c_pulse;
    logic [CNT_W-1:0]       cyc;
    logic [CNT_W-1:0]       k_setup;
    logic [CNT_W-1:0]       k_pulse;
    logic [1:0]             wmode;
    logic [TDF_W-1:0]       tdf;
    logic                   topt;
    logic [TDF_W-1:0]       float_left;
    logic [CS_W-1:0]        float_cs;
    logic                   float_opt;
    logic                   slow;
    logic                   rd_n;
    logic                   wr_n;
    logic [NUM_CS-1:0]      cs_n;
    logic                   done;
    logic                   int_done;
    logic                   frozen;
  } smw_ctl_t;

  smw_ctl_t q;
  smw_ctl_t next_q;
  logic     wait_sync_n;

  // ----------------------------------------------------------------
  // wait input resynchronisation
  // ----------------------------------------------------------------
  // the two cycles spent here are why the pulse must cover latency plus three
  smw_sync #(
    .RST_VAL (RST_WAIT_N)
  ) u_wait_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .d      (ext_wait_n),
    .q      (wait_sync_n)
  ); // [R16]

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_win(input logic [CNT_W-1:0] c,
                                  input logic [CNT_W-1:0] s,
                                  input logic [CNT_W-1:0] p);
    logic [CNT_W:0] e;
    e = {1'b0, s} + {1'b0, p};
    in_win = ({1'b0, c} >= {1'b0, s}) && ({1'b0, c} < e);
  endfunction

  // request parameters, replaced by the fixed set in slow mode
  logic [CNT_W-1:0] r_s_setup;
  logic [CNT_W-1:0] r_s_pulse;
  logic [CNT_W-1:0] r_c_setup;
  logic [CNT_W-1:0] r_c_pulse;
  logic [CNT_W-1:0] r_cyc;
  logic [CNT_W-1:0] r_k_setup;
  logic [CNT_W-1:0] r_k_pulse;
  logic             r_strobe_ctl;

  // ----------------------------------------------------------------
  // waveform selection for the pending request
  // ----------------------------------------------------------------
  always_comb begin
    r_strobe_ctl = ext_write | read_mode[ext_cs];
    if (q.slow) begin
      // fixed shapes, same on every select
      r_strobe_ctl = 1'b1;
      if (ext_write) begin
        r_s_setup = SLOW_WR_SETUP;    // [R19]
        r_s_pulse = SLOW_WR_PULSE;
        r_c_setup = SLOW_CS_WR_SETUP;
        r_c_pulse = SLOW_CS_WR_PULSE;
        r_cyc     = SLOW_WR_CYCLE;
      end else begin
        r_s_setup = SLOW_RD_SETUP;    // [R18]
        r_s_pulse = SLOW_RD_PULSE;
        r_c_setup = SLOW_CS_RD_SETUP;
        r_c_pulse = SLOW_CS_RD_PULSE;
        r_cyc     = SLOW_RD_CYCLE;
      end
    end else if (ext_write) begin
      r_s_setup = write_strobe_setup;
      r_s_pulse = write_strobe_pulse;
      r_c_setup = cs_write_setup;
      r_c_pulse = cs_write_pulse;
      r_cyc     = write_cycle_len;
    end else begin
      r_s_setup = read_strobe_setup;
      r_s_pulse = read_strobe_pulse;
      r_c_setup = cs_read_setup;
      r_c_pulse = cs_read_pulse;
      r_cyc     = read_cycle_len;
    end
    // controlling signal: strobe for writes and slow reads, per select for other reads
    r_k_setup = r_strobe_ctl ? r_s_setup : r_c_setup;  // [R5] [R6]
    r_k_pulse = r_strobe_ctl ? r_s_pulse : r_c_pulse;
  end

  logic             float_hit;
  logic             float_block;
  logic             k_in_pulse;
  logic             k_last_pulse;
  logic             last_cycle;
  logic [CNT_W-1:0] hold_len;
  logic [CNT_W:0]   k_end;
  logic             active;

  // ----------------------------------------------------------------
  // float hazard check and access phase decode
  // ----------------------------------------------------------------
  always_comb begin
    // a read after a read on the same select needs no float gap
    float_hit = (q.float_left != RST_FLOAT) && (ext_write || (ext_cs != q.float_cs)); // [R1] [R2]
    if (q.float_opt) begin
      // setup of the next access runs while the bus floats
      float_block = float_hit && ({{(CNT_W-TDF_W){1'b0}}, q.float_left} > r_k_setup); // [R7]
    end else begin
      float_block = float_hit;  // [R8]
    end
    k_end        = {1'b0, q.k_setup} + {1'b0, q.k_pulse};
    k_in_pulse   = in_win(q.cnt, q.k_setup, q.k_pulse);                      // [R12]
    k_last_pulse = ({1'b0, q.cnt} + 11'h001) == k_end;
    last_cycle   = ({1'b0, q.cnt} + 11'h001) >= {1'b0, q.cyc};
    hold_len     = q.cyc - k_end[CNT_W-1:0];
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_q          = q;
    next_q.done     = 1'b0;
    next_q.frozen   = 1'b0;
    // internal memories are answered without regard to float
    next_q.int_done = int_req;  // [R4]
    // float time elapses whatever the bus is doing
    if (q.float_left != RST_FLOAT) begin
      next_q.float_left = q.float_left - 4'h1;
    end
    case (q.st)
      ST_IDLE,
      ST_FLOAT: begin
        next_q.st = ST_IDLE;
        if (slow_clock != q.slow) begin
          // only reached between transfers
          next_q.st = ST_RELOAD;  // [R21]
        end else if (ext_req && !q.done) begin
          if (float_block) begin
            next_q.st = ST_FLOAT;
          end else begin
            next_q.st      = ST_ACCESS;
            next_q.cnt     = '0;
            next_q.wr      = ext_write;
            next_q.cs      = ext_cs;
            // latched here so a clock change mid transfer keeps the shape
            next_q.s_setup = r_s_setup;  // [R20]
            next_q.s_pulse = r_s_pulse;
            next_q.c_setup = r_c_setup;
            next_q.c_pulse = r_c_pulse;
            next_q.cyc     = r_cyc;
            next_q.k_setup = r_k_setup;
            next_q.k_pulse = r_k_pulse;
            next_q.tdf     = float_cycles[ext_cs];  // [R3]
            next_q.topt    = float_opt[ext_cs];
            // wait is not honoured with slow waveforms
            next_q.wmode   = q.slow ? WMODE_OFF : ext_wait_mode[ext_cs]; // [R10] [R11]
          end
        end
      end
      ST_RELOAD: begin
        next_q.slow = slow_clock;  // [R17]
        next_q.st   = ST_IDLE;
      end
      ST_ACCESS: begin
        if ((q.wmode == WMODE_FROZEN) && k_in_pulse && !wait_sync_n) begin
          next_q.frozen = 1'b1;  // [R13]
        end else if ((q.wmode == WMODE_READY) && k_last_pulse && !wait_sync_n) begin
          // earlier pulse cycles ignore the wait level
          next_q.st = ST_SUSPEND;  // [R14] [R15]
        end else if (last_cycle) begin
          next_q.st   = ST_IDLE;
          next_q.done = 1'b1;
          if (!q.wr) begin
            // hold cycles already covered part of the float time
            if ({{(CNT_W-TDF_W){1'b0}}, q.tdf} > hold_len) begin
              next_q.float_left = q.tdf - hold_len[TDF_W-1:0];  // [R9]
            end else begin
              next_q.float_left = RST_FLOAT;
            end
            next_q.float_cs  = q.cs;
            next_q.float_opt = q.topt;
          end
        end else begin
          next_q.cnt = q.cnt + 10'h001;
        end
      end
      ST_SUSPEND: begin
        if (wait_sync_n) begin
          // hold phase of the access goes ahead
          next_q.st  = ST_ACCESS;  // [R14]
          next_q.cnt = q.cnt + 10'h001;
        end
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase
    // strobes follow the next position; frozen and suspended keep it
    active         = (next_q.st == ST_ACCESS) || (next_q.st == ST_SUSPEND);
    next_q.rd_n    = !(active && !next_q.wr && in_win(next_q.cnt, next_q.s_setup, next_q.s_pulse));
    next_q.wr_n    = !(active && next_q.wr && in_win(next_q.cnt, next_q.s_setup, next_q.s_pulse));
    next_q.cs_n    = '1;
    if (active && in_win(next_q.cnt, next_q.c_setup, next_q.c_pulse)) begin
      next_q.cs_n[next_q.cs] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset leaves nothing pending, frozen or suspended
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q            <= '0;  // [R22]
      q.st         <= ST_IDLE;
      q.float_left <= RST_FLOAT;
      q.rd_n       <= 1'b1;
      q.wr_n       <= 1'b1;
      q.cs_n       <= '1;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign read_strobe_n  = q.rd_n;
  assign write_strobe_n = q.wr_n;
  assign chip_select_n  = q.cs_n;
  assign ext_done       = q.done;
  assign int_done       = q.int_done;
  assign float_left     = q.float_left;
  assign wait_frozen    = q.frozen;
  assign wait_suspended = q.st[4];
  assign slow_active    = q.slow;

endmodule

/* bench/smw_wait_ctrl_assertions.sv */
`timescale 1ns/1ns
module smw_wait_ctrl_assertions
  import smw_pkg::*;
#(
  parameter int NUM_CS = smw_pkg::NUM_CS,
  parameter int CS_W   = smw_pkg::CS_W,
  parameter int TDF_W  = smw_pkg::TDF_W
) (
  input wire logic                         clk,            // master clock
  input wire logic                         resetn,         // async reset, active low
  input wire logic                         int_req,        // internal request
  input wire logic                         ext_write,      // write access
  input wire logic [CS_W-1:0]              ext_cs,         // target select
  input wire logic [NUM_CS-1:0][TDF_W-1:0] float_cycles,   // float counts
  input wire logic [NUM_CS-1:0][1:0]       ext_wait_mode,  // wait modes
  input wire logic                         read_strobe_n,  // read strobe
  input wire logic                         write_strobe_n, // write strobe
  input wire logic [NUM_CS-1:0]            chip_select_n,  // chip selects
  input wire logic                         ext_done,       // access done
  input wire logic                         int_done,       // internal done
  input wire logic [TDF_W-1:0]             float_left,     // pending float
  input wire logic                         wait_frozen,    // frozen flag
  input wire logic                         wait_suspended, // suspended flag
  input wire logic                         slow_active     // slow waveforms
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  // both strobes back high one cycle after a fall
  sequence s_strobe_back;
    ##1 (read_strobe_n && write_strobe_n);
  endsequence
  // float time, reset and internal path
  property p_reset_idle;
    $rose(resetn) |-> float_left == '0 && &chip_select_n && !ext_done;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
  property p_float_count;
    float_left != '0 && !ext_done |=> ext_done || float_left + 1'b1 == $past(float_left);
  endproperty
  a_float_count: assert property (p_float_count) else $error("float count stuck");
  property p_zero_float;
    ext_done && !ext_write && float_cycles[ext_cs] == '0 |-> float_left == '0;
  endproperty
  a_zero_float: assert property (p_zero_float) else $error("float without count");
  property p_int_echo;
    int_req |=> int_done;
  endproperty
  a_int_echo: assert property (p_int_echo) else $error("internal access delayed");
  // wait handling: flags only in their mode, outputs held
  property p_frozen_mode;
    wait_frozen |-> ext_wait_mode[ext_cs] == WMODE_FROZEN && !slow_active;
  endproperty
  a_frozen_mode: assert property (p_frozen_mode) else $error("frozen in wrong mode");
  property p_frozen_hold;
    wait_frozen |-> $stable(read_strobe_n) && $stable(write_strobe_n) && $stable(chip_select_n);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("outputs moved while frozen");
  property p_ready_mode;
    wait_suspended |-> ext_wait_mode[ext_cs] == WMODE_READY && !(&chip_select_n);
  endproperty
  a_ready_mode: assert property (p_ready_mode) else $error("bad suspension");
  // slow waveforms: one-cycle strobes, switch only between accesses
  property p_slow_strobe;
    slow_active && ($fell(read_strobe_n) || $fell(write_strobe_n)) |-> s_strobe_back;
  endproperty
  a_slow_strobe: assert property (p_slow_strobe) else $error("slow strobe too long");
  property p_reload;
    $changed(slow_active) |-> &chip_select_n;
  endproperty
  a_reload: assert property (p_reload) else $error("mode switch mid access");
endmodule

bind smw_wait_ctrl smw_wait_ctrl_assertions #(.NUM_CS(NUM_CS), .CS_W(CS_W), .TDF_W(TDF_W))
  smw_wait_ctrl_assertions_inst (
  .clk(clk), .resetn(resetn), .int_req(int_req), .ext_write(ext_write), .ext_cs(ext_cs),
  .float_cycles(float_cycles), .ext_wait_mode(ext_wait_mode), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n), .ext_done(ext_done),
  .int_done(int_done), .float_left(float_left), .wait_frozen(wait_frozen),
  .wait_suspended(wait_suspended), .slow_active(slow_active));

/* bench/smw_ext_mem.sv */
`timescale 1ns/1ns
module smw_ext_mem (
  input  wire logic       clk,            // master clock
  input  wire logic       resetn,         // reset, active low
  input  wire logic       read_strobe_n,  // read strobe from controller
  input  wire logic       write_strobe_n, // write strobe from controller
  input  wire logic [4:0] wait_len,       // cycles to hold wait low
  output logic            ext_wait_n      // wait, pulled up when released
);
  logic       strobe_q;
  logic [4:0] left;
  // answer each strobe fall one cycle later, well inside the pulse
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_q <= 1'b1;
      left <= 5'h00;
    end else begin
      strobe_q <= read_strobe_n & write_strobe_n;
      if (strobe_q && !(read_strobe_n & write_strobe_n)) begin
        left <= wait_len;
      end else if (left != 5'h00) begin
        left <= left - 5'h01;
      end
    end
  end
  // released line rests at the pull-up level
  assign ext_wait_n = (left == 5'h00);
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t, line %0d", $time, `__LINE__); end end
module tb_top;
  import smw_pkg::*;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic                         clk, resetn, slow_clock, int_req, ext_req, ext_write;
  logic                         seen_susp = 1'b0;
  logic [CS_W-1:0]              ext_cs;
  // read 1/8/10, select 0/10; write 3/4/8, select 0/8: one hold cycle after each strobe, none after a select
  logic [CNT_W-1:0]             tim [10] = '{10'h001, 10'h008, 10'h00a, 10'h000, 10'h00a,
                                             10'h003, 10'h004, 10'h008, 10'h000, 10'h008};
  logic [NUM_CS-1:0]            read_mode = 8'hdd;
  logic [NUM_CS-1:0]            float_opt = 8'h04;
  logic [NUM_CS-1:0][TDF_W-1:0] float_cycles = 32'h00f0_0366;
  logic [NUM_CS-1:0][1:0]       ext_wait_mode = 16'h0000;
  logic [NUM_CS-1:0]            chip_select_n;
  logic                         ext_wait_n, read_strobe_n, write_strobe_n, ext_done, int_done;
  logic                         wait_frozen, wait_suspended, slow_active;
  logic [TDF_W-1:0]             float_left, fl;
  logic [4:0]                   wait_len;
  int                           n_errors, n_checks, n, n_frz, n_lo, lo;

  smw_wait_ctrl smw_wait_ctrl_inst (
    .clk(clk), .resetn(resetn), .ce(1'b1), .slow_clock(slow_clock), .int_req(int_req),
    .ext_req(ext_req), .ext_write(ext_write), .ext_cs(ext_cs),
    .read_strobe_setup(tim[0]), .read_strobe_pulse(tim[1]), .read_cycle_len(tim[2]),
    .cs_read_setup(tim[3]), .cs_read_pulse(tim[4]), .write_strobe_setup(tim[5]),
    .write_strobe_pulse(tim[6]), .write_cycle_len(tim[7]), .cs_write_setup(tim[8]), .cs_write_pulse(tim[9]),
    .read_mode(read_mode), .float_opt(float_opt), .float_cycles(float_cycles), .ext_wait_mode(ext_wait_mode),
    .ext_wait_n(ext_wait_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .chip_select_n(chip_select_n), .ext_done(ext_done), .int_done(int_done), .float_left(float_left),
    .wait_frozen(wait_frozen), .wait_suspended(wait_suspended), .slow_active(slow_active));
  smw_ext_mem smw_ext_mem_inst (.clk(clk), .resetn(resetn), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .wait_len(wait_len), .ext_wait_n(ext_wait_n));

  // clock, suspension seen flag, frozen and strobe-low cycle counts
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (wait_suspended === 1'b1) seen_susp <= 1'b1;
    if (wait_frozen === 1'b1) n_frz <= n_frz + 1;
    if (read_strobe_n === 1'b0 || write_strobe_n === 1'b0) n_lo <= n_lo + 1;
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one access held until done; n counts edges to done, lo strobe-low cycles
  task automatic acc(input logic w, input logic [CS_W-1:0] cs);
    int lo0;
    @(posedge clk);
    #1;
    ext_write = w;
    ext_cs = cs;
    ext_req = 1'b1;
    n = 0;
    lo0 = n_lo;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ext_done !== 1'b1 && n < 500);
    fl = float_left;
    lo = n_lo - lo0;
    ext_req = 1'b0;
    if (n >= 500) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // reload cycle must be bounded
  task automatic wait_slow(input logic v);
    int k;
    k = 0;
    while (slow_active !== v && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(slow_active, v)
    if (k >= 50) end_of_test();
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    slow_clock = 1'b0;
    int_req = 1'b0;
    ext_req = 1'b0;
    ext_write = 1'b0;
    ext_cs = '0;
    wait_len = 5'h00;
    n_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    #1;
    resetn = 1'b1;
    `CHK(float_left, 4'h0)
    `CHK(chip_select_n, 8'hff)
    acc(1'b0, 3'h5);
    `CHK(fl, 4'hf)
    int_req = 1'b1;
    @(posedge clk);
    #1;
    int_req = 1'b0;
    `CHK(int_done, 1'b1)
    acc(1'b0, 3'h4);
    `CHK(n > 11, 1'b1)
    `CHK(fl, 4'h0)
    acc(1'b0, 3'h0);
    `CHK(n, 11)
    `CHK(fl, 4'h5)
    acc(1'b0, 3'h0);
    `CHK(n, 11)
    acc(1'b1, 3'h0);
    `CHK(n > 9, 1'b1)
    acc(1'b0, 3'h1);
    `CHK(fl, 4'h6)
    acc(1'b0, 3'h2);
    `CHK(n > 11, 1'b1)
    `CHK(fl, 4'h2)
    acc(1'b1, 3'h2);
    `CHK(n, 9)
    wait_len = 5'h03;
    acc(1'b0, 3'h3);
    `CHK(n, 11)
    `CHK(n_frz, 0)
    ext_wait_mode[3] = WMODE_FROZEN;
    acc(1'b0, 3'h3);
    `CHK(n, 14)
    `CHK(lo, 11)
    `CHK(n_frz, 3)
    ext_wait_mode[3] = WMODE_READY;
    wait_len = 5'h02;
    acc(1'b0, 3'h3);
    `CHK(n, 11)
    `CHK(n_frz, 3)
    wait_len = 5'h14;
    acc(1'b0, 3'h3);
    `CHK(n > 11, 1'b1)
    `CHK(seen_susp, 1'b1)
    slow_clock = 1'b1;
    wait_slow(1'b1);
    acc(1'b0, 3'h3);
    `CHK(n, 3)
    `CHK(lo, 1)
    acc(1'b1, 3'h0);
    `CHK(n, 4)
    `CHK(lo, 1)
    fork
      acc(1'b1, 3'h0);
      begin
        repeat (2) @(posedge clk);
        #1;
        slow_clock = 1'b0;
      end
    join
    `CHK(n, 4)
    `CHK(lo, 1)
    wait_slow(1'b0);
    acc(1'b0, 3'h5);
    resetn = 1'b0;
    @(posedge clk);
    #1;
    resetn = 1'b1;
    `CHK(float_left, 4'h0)
    `CHK(wait_suspended, 1'b0)
    // reset in the middle of a suspended access; the held request is retaken
    fork
      acc(1'b0, 3'h3);
      begin
        repeat (12) @(posedge clk);
        #1;
        `CHK(wait_suspended, 1'b1)
        resetn = 1'b0;
        @(posedge clk);
        #1;
        resetn = 1'b1;
        `CHK(wait_suspended, 1'b0)
        `CHK(chip_select_n, 8'hff)
      end
    join
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule
